/* inc/bundle_dec_pkg.sv */
// shared constants, types and decode helpers for the bundle immediate decoder
package bundle_dec_pkg;

    // ************************************************************
    // syllable layout
    // ************************************************************
    localparam int SYL_W = 32;
    localparam int MAX_SYL = 4;
    localparam int STOP_BIT = 31;
    localparam int EXT_OPC_HI = 29;
    localparam int EXT_OPC_LO = 24;
    localparam logic [5:0] EXT_OPC = 6'h15;
    localparam int EXT_DIR_BIT = 23;
    localparam logic EXT_DIR_RIGHT = 1'b1;
    localparam int EXT_VAL_W = 23;
    localparam int OPC_HI = 29;
    localparam int OPC_LO = 21;
    localparam int SIMM_HI = 20;
    localparam int SIMM_LO = 12;
    localparam int SIMM_W = 9;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_BUNDLES = 12'h008;
    localparam logic [11:0] OFS_RECOV = 12'h00c;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int ST_FATAL_BIT = 0;
    localparam int ST_PLACE_BIT = 1;
    localparam int ST_LONG_BIT = 2;
    localparam int ST_PHASE_LO = 4;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        PH_COLLECT = 2'b00,
        PH_PRE = 2'b01,
        PH_COMMIT = 2'b11,
        PH_HALT = 2'b10
    } phase_e;

    function automatic logic is_ext(input logic [31:0] w);
        is_ext = (w[EXT_OPC_HI:EXT_OPC_LO] == EXT_OPC);
    endfunction

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_BUNDLES) || (a == OFS_RECOV);
    endfunction

endpackage

/* hw/imm_former.sv */
// full immediate builder for one operation slot
`timescale 1ns/1ns
module imm_former (
    input wire logic [8:0] short_imm,
    input wire logic left_hit,
    input wire logic [22:0] left_ext,
    input wire logic right_hit,
    input wire logic [22:0] right_ext,
    output logic [31:0] full_imm,
    output logic ext_used
);
    logic [22:0] ext;

    always_comb begin
        // a right-associating word on the left wins if both neighbours claim the slot
        ext = left_hit ? left_ext : right_ext;
        ext_used = left_hit | right_hit;
        if (ext_used) begin
            // (ext << 9) + zero-extended short field; the two never overlap
            full_imm = {ext, 9'h000} + {23'h000000, short_imm}; // RQ6 RQ7
        end else begin
            full_imm = {{23{short_imm[8]}}, short_imm}; // RQ7 RQ4
        end
    end
endmodule

/* hw/vliw_bundle_immediate_decoder.sv */
// bundle splitter, immediate joiner and commit sequencer with apb control
// Functional notes
// [RQ1] bundle is one to four consecutive words
// [RQ2] set bit 31 closes the bundle
// [RQ3] each syllable is operation or extension
// [RQ4] short immediate is nine bits only
// [RQ5] extension opcode; bit 23 picks side
// [RQ6] joined immediate is ext shifted plus short
// [RQ7] low 23 ext bits; else sign-extend short
// [RQ8] extensions only at even word addresses
// [RQ9] multiplies only at odd word addresses
// [RQ10] one control-flow op, first slot only
// [RQ11] at most one load or store
// [RQ12] producer keeps placement, hardware may rely
// [RQ13] pre-commit changes no state, raises exceptions
// [RQ14] commit only after clean pre-commit
// [RQ15] bus error in commit is non-recoverable
// [RQ16] some ops never target link_reg
// [RQ17] opcode 29:21, short immediate 20:12
// [RQ18] extensions are never issued as operations
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ns
module vliw_bundle_immediate_decoder #(
    parameter int ADDR_W = 30
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_word,
    input wire logic [ADDR_W-1:0] fetch_addr,
    output logic fetch_ready,
    output logic bundle_valid,
    output logic [bundle_dec_pkg::MAX_SYL-1:0] slot_op_valid,
    output logic [bundle_dec_pkg::MAX_SYL*32-1:0] slot_word,
    output logic [bundle_dec_pkg::MAX_SYL*32-1:0] slot_imm,
    output logic [bundle_dec_pkg::MAX_SYL-1:0] slot_imm_ext,
    input wire logic pre_done,
    input wire logic pre_exc,
    output logic commit_en,
    input wire logic commit_done,
    input wire logic bus_err,
    output logic recov_exc,
    output logic fatal_err
);
    localparam int NS = bundle_dec_pkg::MAX_SYL;

    // ************************************************************
    // bundle collection and phase state
    // ************************************************************
    bundle_dec_pkg::phase_e phase, next_phase;
    logic [31:0] syl [NS];
    logic [31:0] next_syl [NS];
    logic [2:0] cnt, next_cnt;
    logic [ADDR_W-1:0] base, next_base;
    logic next_fetch_ready, next_bundle_valid, next_commit_en, next_recov_exc;
    logic [NS-1:0] next_slot_op_valid, next_slot_imm_ext;
    logic [NS*32-1:0] next_slot_word, next_slot_imm;
    logic ev_commit, ev_recov, ev_fatal, ev_place, ev_long, accept, closing;
    logic ctrl_en;

    // decode of the bundle being closed
    logic [NS-1:0] dec_ext, dec_op, dec_used, dec_bad;
    logic [31:0] dec_imm [NS];

    assign accept = fetch_valid & fetch_ready;

    for (genvar i = 0; i < NS; i++) begin : g_slot
        logic left_hit, right_hit;
        logic [22:0] left_ext, right_ext;
        assign dec_ext[i] = (i < next_cnt) && bundle_dec_pkg::is_ext(next_syl[i]); // RQ3 RQ5
        assign dec_op[i] = (i < next_cnt) && !dec_ext[i]; // RQ3
        if (i > 0) begin : g_left
            assign left_hit = dec_ext[i-1] &&
                (next_syl[i-1][bundle_dec_pkg::EXT_DIR_BIT] == bundle_dec_pkg::EXT_DIR_RIGHT); // RQ5 RQ6
            assign left_ext = next_syl[i-1][bundle_dec_pkg::EXT_VAL_W-1:0]; // RQ7
        end else begin : g_noleft
            assign left_hit = 1'b0;
            assign left_ext = 23'h000000;
        end
        if (i < NS - 1) begin : g_right
            assign right_hit = dec_ext[i+1] &&
                (next_syl[i+1][bundle_dec_pkg::EXT_DIR_BIT] != bundle_dec_pkg::EXT_DIR_RIGHT); // RQ5 RQ6
            assign right_ext = next_syl[i+1][bundle_dec_pkg::EXT_VAL_W-1:0]; // RQ7
        end else begin : g_noright
            assign right_hit = 1'b0;
            assign right_ext = 23'h000000;
        end
        imm_former u_imm (
            .short_imm(next_syl[i][bundle_dec_pkg::SIMM_HI:bundle_dec_pkg::SIMM_LO]), // RQ17 RQ4
            .left_hit(left_hit & dec_op[i]),
            .left_ext(left_ext),
            .right_hit(right_hit & dec_op[i]),
            .right_ext(right_ext),
            .full_imm(dec_imm[i]),
            .ext_used(dec_used[i])
        );
    end

    // placement is the producer's job; a misplaced extension is only flagged, never fixed up
    always_comb begin
        dec_bad = '0;
        for (int i = 0; i < NS; i++) begin
            if (dec_ext[i]) begin
                if (next_base[0] ^ ((i % 2) == 1)) begin
                    dec_bad[i] = 1'b1; // RQ8 RQ12
                end
                if (next_syl[i][bundle_dec_pkg::EXT_DIR_BIT] == bundle_dec_pkg::EXT_DIR_RIGHT) begin
                    if (i == NS - 1 || !dec_op[(i + 1) % NS]) begin
                        dec_bad[i] = 1'b1;
                    end
                end else if (i == 0 || !dec_op[(i + NS - 1) % NS]) begin
                    dec_bad[i] = 1'b1;
                end
            end
        end
    end

    always_comb begin
        next_phase = phase;
        next_syl = syl;
        next_cnt = cnt;
        next_base = base;
        next_recov_exc = 1'b0;
        ev_commit = 1'b0;
        ev_recov = 1'b0;
        ev_fatal = 1'b0;
        ev_long = 1'b0;
        closing = 1'b0;
        case (phase)
            bundle_dec_pkg::PH_COLLECT: begin
                if (accept) begin
                    next_syl[cnt[1:0]] = fetch_word; // RQ1
                    if (cnt == 3'h0) begin
                        next_base = fetch_addr;
                    end
                    next_cnt = cnt + 3'h1;
                    if (fetch_word[bundle_dec_pkg::STOP_BIT]) begin
                        closing = 1'b1; // RQ2
                    end else if (cnt == 3'(NS - 1)) begin
                        // no stop bit after four words: close anyway and flag it
                        closing = 1'b1; // RQ1
                        ev_long = 1'b1;
                    end
                    if (closing) begin
                        next_phase = bundle_dec_pkg::PH_PRE;
                    end
                end
            end
            bundle_dec_pkg::PH_PRE: begin
                if (pre_done && pre_exc) begin
                    next_phase = bundle_dec_pkg::PH_COLLECT; // RQ13
                    next_recov_exc = 1'b1;
                    ev_recov = 1'b1;
                    next_cnt = 3'h0;
                end else if (pre_done) begin
                    next_phase = bundle_dec_pkg::PH_COMMIT; // RQ14
                end
            end
            bundle_dec_pkg::PH_COMMIT: begin
                if (bus_err) begin
                    next_phase = bundle_dec_pkg::PH_HALT; // RQ15
                    ev_fatal = 1'b1;
                end else if (commit_done) begin
                    next_phase = bundle_dec_pkg::PH_COLLECT;
                    ev_commit = 1'b1;
                    next_cnt = 3'h0;
                end
            end
            bundle_dec_pkg::PH_HALT: begin
                // stays halted until software clears the fatal flag
                if (!fatal_err) begin
                    next_phase = bundle_dec_pkg::PH_COLLECT;
                    next_cnt = 3'h0;
                end
            end
            default: begin
                next_phase = bundle_dec_pkg::PH_COLLECT;
                next_cnt = 3'h0;
            end
        endcase
        ev_place = closing && (dec_bad != '0);
        next_fetch_ready = (next_phase == bundle_dec_pkg::PH_COLLECT) && ctrl_en;
        next_bundle_valid = (next_phase == bundle_dec_pkg::PH_PRE) || (next_phase == bundle_dec_pkg::PH_COMMIT);
        next_commit_en = (next_phase == bundle_dec_pkg::PH_COMMIT); // RQ13 RQ14
        next_slot_op_valid = next_bundle_valid ? slot_op_valid : '0;
        next_slot_imm_ext = slot_imm_ext;
        next_slot_word = slot_word;
        next_slot_imm = slot_imm;
        if (closing) begin
            next_slot_op_valid = dec_op; // RQ18
            next_slot_imm_ext = dec_used & dec_op;
            for (int i = 0; i < NS; i++) begin
                next_slot_word[i*32 +: 32] = next_syl[i];
                next_slot_imm[i*32 +: 32] = dec_imm[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= bundle_dec_pkg::PH_COLLECT;
            for (int i = 0; i < NS; i++) begin
                syl[i] <= 32'h0000_0000;
            end
            cnt <= 3'h0;
            base <= '0;
            fetch_ready <= 1'b0;
            bundle_valid <= 1'b0;
            commit_en <= 1'b0;
            recov_exc <= 1'b0;
            slot_op_valid <= '0;
            slot_imm_ext <= '0;
            slot_word <= '0;
            slot_imm <= '0;
        end else begin
            phase <= next_phase;
            syl <= next_syl;
            cnt <= next_cnt;
            base <= next_base;
            fetch_ready <= next_fetch_ready;
            bundle_valid <= next_bundle_valid;
            commit_en <= next_commit_en;
            recov_exc <= next_recov_exc;
            slot_op_valid <= next_slot_op_valid;
            slot_imm_ext <= next_slot_imm_ext;
            slot_word <= next_slot_word;
            slot_imm <= next_slot_imm;
        end
    end

    // ************************************************************
    // apb registers
    // ************************************************************
    logic next_ctrl_en, next_pready, next_pslverr;
    logic [31:0] next_prdata, bundles, next_bundles, recovs, next_recovs;
    logic st_place, st_long, next_fatal_err, next_st_place, next_st_long, wr_status;

    always_comb begin
        next_ctrl_en = ctrl_en;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        wr_status = psel && penable && pready && pwrite && (paddr == bundle_dec_pkg::OFS_STATUS);
        if (psel && penable && pready && pwrite && (paddr == bundle_dec_pkg::OFS_CTRL)) begin
            next_ctrl_en = pwdata[bundle_dec_pkg::CTRL_EN_BIT];
        end
        // read data is built in the setup cycle so that the access cycle can finish at once
        if (psel && !penable) begin
            next_pready = 1'b1;
            next_pslverr = !bundle_dec_pkg::addr_hit(paddr);
            case (paddr)
                bundle_dec_pkg::OFS_CTRL: next_prdata = {31'h0000_0000, ctrl_en};
                bundle_dec_pkg::OFS_STATUS: next_prdata = {26'h000_0000, phase, 1'b0, st_long, st_place, fatal_err};
                bundle_dec_pkg::OFS_BUNDLES: next_prdata = bundles;
                bundle_dec_pkg::OFS_RECOV: next_prdata = recovs;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        // sticky flags: a new event outweighs a clear in the same cycle
        next_fatal_err = (fatal_err & !(wr_status & pwdata[bundle_dec_pkg::ST_FATAL_BIT])) | ev_fatal; // RQ15
        next_st_place = (st_place & !(wr_status & pwdata[bundle_dec_pkg::ST_PLACE_BIT])) | ev_place;
        next_st_long = (st_long & !(wr_status & pwdata[bundle_dec_pkg::ST_LONG_BIT])) | ev_long;
        next_bundles = ev_commit ? bundles + 32'h0000_0001 : bundles;
        next_recovs = ev_recov ? recovs + 32'h0000_0001 : recovs;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en <= bundle_dec_pkg::CTRL_EN_RST;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            fatal_err <= 1'b0;
            st_place <= 1'b0;
            st_long <= 1'b0;
            bundles <= bundle_dec_pkg::CNT_RST;
            recovs <= bundle_dec_pkg::CNT_RST;
        end else begin
            ctrl_en <= next_ctrl_en;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
            fatal_err <= next_fatal_err;
            st_place <= next_st_place;
            st_long <= next_st_long;
            bundles <= next_bundles;
            recovs <= next_recovs;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    logic [NS-1:0] out_is_ext;
    logic [31:0] w0, w1, w2, im1;
    for (genvar i = 0; i < NS; i++) begin : g_chk
        assign out_is_ext[i] = bundle_dec_pkg::is_ext(slot_word[i*32 +: 32]);
    end
    assign w0 = slot_word[31:0];
    assign w1 = slot_word[63:32];
    assign w2 = slot_word[95:64];
    assign im1 = slot_imm[63:32];

    sequence seq_pre_fail;
        phase == bundle_dec_pkg::PH_PRE && pre_done && pre_exc;
    endsequence
    sequence seq_pre_ok;
        phase == bundle_dec_pkg::PH_PRE && pre_done && !pre_exc;
    endsequence

    a_stop_closes: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        accept && fetch_word[31] |=> bundle_valid && !fetch_ready && !commit_en)
        else $error("stop bit did not close the bundle");
    a_four_max: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
        accept && !fetch_word[31] && cnt == 3'h3 |=> bundle_valid && slot_op_valid[3] == !out_is_ext[3])
        else $error("fourth syllable did not close the bundle");
    a_ext_dropped: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
        bundle_valid |-> (slot_op_valid & out_is_ext) == '0)
        else $error("extension issued as an operation");
    a_imm_joined: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        bundle_valid && slot_imm_ext[1] |-> im1[8:0] == w1[20:12] &&
        ((im1[31:9] == w0[22:0] && out_is_ext[0] && w0[23]) || (im1[31:9] == w2[22:0] && out_is_ext[2] && !w2[23])))
        else $error("joined immediate wrong");
    a_imm_short: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        bundle_valid && slot_op_valid[1] && !slot_imm_ext[1] |-> im1 == {{23{w1[20]}}, w1[20:12]})
        else $error("short immediate not sign-extended");
    a_fail_no_commit: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
        seq_pre_fail |=> recov_exc && !commit_en ##1 !commit_en && !recov_exc)
        else $error("commit after pre-commit exception");
    a_ok_commits: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
        seq_pre_ok |=> commit_en && bundle_valid && !recov_exc)
        else $error("clean pre-commit did not commit");
    a_commit_cause: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
        $rose(commit_en) |-> $past(phase) == bundle_dec_pkg::PH_PRE && $past(pre_done) && !$past(pre_exc))
        else $error("commit without clean pre-commit");
    a_bus_fatal: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
        commit_en && bus_err |=> fatal_err && !commit_en && !recov_exc && !fetch_ready)
        else $error("bus error not treated as fatal");
endmodule

/* tb/fetch_pipe_model.sv */
// far-side model: fetch unit offering words and pipeline answering the bundle phases
`timescale 1ns/1ns
module fetch_pipe_model #(
    parameter int ADDR_W = 30
) (
    input wire logic pclk,
    input wire logic fetch_ready,
    input wire logic bundle_valid,
    input wire logic commit_en,
    output logic fetch_valid,
    output logic [31:0] fetch_word,
    output logic [ADDR_W-1:0] fetch_addr,
    output logic pre_done,
    output logic pre_exc,
    output logic commit_done,
    output logic bus_err
);
    initial begin
        fetch_valid = 1'b0;
        fetch_word = 32'h0000_0000;
        fetch_addr = '0;
        pre_done = 1'b0;
        pre_exc = 1'b0;
        commit_done = 1'b0;
        bus_err = 1'b0;
    end

    // ************************************************************
    // fetch side
    // ************************************************************
    // callers keep the producer's placement rules, except sc_odd, which sends a misplaced extension to see it flagged
    // waits here end only at the bench ceiling, never silently
    task automatic send(input logic [127:0] w, input int n, input logic [ADDR_W-1:0] base);
        @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            fetch_valid <= 1'b1;
            fetch_word <= w[32*i+:32];
            fetch_addr <= base + ADDR_W'(i);
            do begin
                @(posedge pclk);
            end while (fetch_ready !== 1'b1);
        end
        fetch_valid <= 1'b0;
        // released lines flip so a stale word is never mistaken for a live one
        fetch_word <= ~fetch_word;
        fetch_addr <= ~fetch_addr;
    endtask

    // ************************************************************
    // pipeline side
    // ************************************************************
    task automatic precommit(input logic exc);
        do begin
            @(posedge pclk);
        end while (bundle_valid !== 1'b1);
        pre_done <= 1'b1;
        pre_exc <= exc;
        @(posedge pclk);
        pre_done <= 1'b0;
        pre_exc <= ~exc;
    endtask

    task automatic commit(input logic err);
        do begin
            @(posedge pclk);
        end while (commit_en !== 1'b1);
        commit_done <= ~err;
        bus_err <= err;
        @(posedge pclk);
        commit_done <= 1'b0;
        bus_err <= 1'b0;
    endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the bundle immediate decoder
`timescale 1ns/1ns
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, fetch_word;
    logic fetch_valid, fetch_ready, bundle_valid, pre_done, pre_exc, commit_en;
    logic commit_done, bus_err, recov_exc, fatal_err;
    logic [29:0] fetch_addr;
    logic [3:0] slot_op_valid, slot_imm_ext;
    logic [127:0] slot_word, slot_imm;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    vliw_bundle_immediate_decoder i_vliw_bundle_immediate_decoder (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .fetch_valid, .fetch_word, .fetch_addr, .fetch_ready,
        .bundle_valid, .slot_op_valid, .slot_word, .slot_imm, .slot_imm_ext, .pre_done, .pre_exc, .commit_en,
        .commit_done, .bus_err, .recov_exc, .fatal_err);

    fetch_pipe_model i_fetch_pipe_model (.pclk, .fetch_ready, .bundle_valid, .commit_en, .fetch_valid,
        .fetch_word, .fetch_addr, .pre_done, .pre_exc, .commit_done, .bus_err);

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench ceiling ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // opcode 9'h040 keeps bits 29:24 clear of the extension pattern
    function automatic logic [31:0] op(input logic s, input logic [8:0] si);
        op = {s, 1'b0, 9'h040, si, 12'h000};
    endfunction

    function automatic logic [31:0] ext(input logic s, input logic r, input logic [22:0] v);
        ext = {s, 1'b0, 6'h15, r, v};
    endfunction

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic sc_regs();
        apb(1'b0, bundle_dec_pkg::OFS_STATUS, 32'h0);
        check("status reset", rd, 32'h0000_0000);
        apb(1'b0, bundle_dec_pkg::OFS_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h0000_0001);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped", {err, rd}, {1'b1, 32'h0000_0000});
        apb(1'b1, bundle_dec_pkg::OFS_BUNDLES, 32'hffff_ffff);
        apb(1'b0, bundle_dec_pkg::OFS_BUNDLES, 32'h0);
        check("count read only", rd, 32'h0000_0000);
        apb(1'b1, bundle_dec_pkg::OFS_CTRL, 32'h0);
        repeat (3) @(posedge pclk);
        #1;
        check("disabled ready", fetch_ready, 1'b0);
        apb(1'b1, bundle_dec_pkg::OFS_CTRL, 32'h1);
    endtask

    task automatic sc_plain();
        logic [127:0] w;
        w = {64'h0, op(1'b1, 9'h005), op(1'b0, 9'h1ff)};
        i_fetch_pipe_model.send(w, 2, 30'h10);
        #1;
        check("closed", {bundle_valid, fetch_ready}, 2'b10);
        check("op valid", slot_op_valid, 4'b0011);
        check("words", slot_word[63:0], w[63:0]);
        check("short imm", slot_imm[63:0], {32'h0000_0005, 32'hffff_ffff});
        check("no join", slot_imm_ext, 4'b0000);
        check("no early commit", commit_en, 1'b0);
        i_fetch_pipe_model.precommit(1'b0);
        #1;
        check("commit on", commit_en, 1'b1);
        i_fetch_pipe_model.commit(1'b0);
        #1;
        check("retired", {commit_en, bundle_valid, fetch_ready}, 3'b001);
        apb(1'b0, bundle_dec_pkg::OFS_BUNDLES, 32'h0);
        check("commit count", rd, 32'h0000_0001);
    endtask

    task automatic sc_recov();
        logic [127:0] w;
        w = {64'h0, ext(1'b1, 1'b0, 23'h000055), op(1'b0, 9'h1f0)};
        i_fetch_pipe_model.send(w, 2, 30'h31);
        #1;
        check("left op valid", slot_op_valid, 4'b0001);
        check("left join", {slot_imm_ext, slot_imm[31:0]}, {4'b0001, 23'h000055, 9'h1f0});
        i_fetch_pipe_model.precommit(1'b1);
        #1;
        check("dropped", {recov_exc, commit_en, bundle_valid}, 3'b100);
        @(posedge pclk);
        #1;
        check("pulse", recov_exc, 1'b0);
        apb(1'b0, bundle_dec_pkg::OFS_RECOV, 32'h0);
        check("recov count", rd, 32'h0000_0001);
    endtask

    task automatic sc_long();
        logic [127:0] w;
        int t;
        w = {op(1'b1, 9'h100), ext(1'b0, 1'b1, 23'h000001), op(1'b0, 9'h0a1), ext(1'b0, 1'b1, 23'h2abcde)};
        i_fetch_pipe_model.send(w, 4, 30'h20);
        #1;
        check("right op valid", slot_op_valid, 4'b1010);
        check("right join", slot_imm_ext, 4'b1010);
        check("imm 1", slot_imm[63:32], {23'h2abcde, 9'h0a1});
        check("imm 3", slot_imm[127:96], 32'h0000_0300);
        i_fetch_pipe_model.precommit(1'b0);
        i_fetch_pipe_model.commit(1'b1);
        #1;
        check("fatal", {fatal_err, commit_en, fetch_ready}, 3'b100);
        apb(1'b0, bundle_dec_pkg::OFS_STATUS, 32'h0);
        check("halted", {rd[5:4], rd[0]}, 3'b101);
        apb(1'b0, bundle_dec_pkg::OFS_BUNDLES, 32'h0);
        check("not counted", rd, 32'h0000_0001);
        apb(1'b1, bundle_dec_pkg::OFS_STATUS, 32'h0000_0001);
        t = 0;
        while (fetch_ready !== 1'b1 && t < 10) begin
            @(posedge pclk);
            t++;
        end
        #1;
        check("resumed", {fatal_err, fetch_ready}, 2'b01);
    endtask

    // four words with no stop bit and an extension with no operation on its side
    task automatic sc_odd();
        logic [127:0] w;
        w = {op(1'b0, 9'h004), op(1'b0, 9'h002), op(1'b0, 9'h003), ext(1'b0, 1'b0, 23'h000007)};
        i_fetch_pipe_model.send(w, 4, 30'h40);
        #1;
        check("overlong closed", {bundle_valid, slot_op_valid, slot_imm_ext}, 9'h1e0);
        apb(1'b0, bundle_dec_pkg::OFS_STATUS, 32'h0);
        check("flags", rd, 32'h0000_0016);
        apb(1'b1, bundle_dec_pkg::OFS_STATUS, 32'h0000_0006);
        apb(1'b0, bundle_dec_pkg::OFS_STATUS, 32'h0);
        check("flags cleared", rd, 32'h0000_0010);
        i_fetch_pipe_model.precommit(1'b1);
        #1;
        check("odd dropped", {recov_exc, bundle_valid}, 2'b10);
    endtask

    // ************************************************************
    // clock, reset, run
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // the whole run is about a hundred cycles; this ceiling only catches a hang
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        sc_regs();
        sc_plain();
        sc_recov();
        sc_long();
        sc_odd();
        end_of_test();
    end
endmodule
